// ---- bench/audio_effect_parameter_control_tb.sv ----
module audio_effect_parameter_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fx_param_pkg::*;
   logic        clk_sys = 0, rst_n = 0, clkEn = 1, effectLoad = 0, send = 0;
   logic [2:0]  effectSel = 0, multIdx;
   logic [3:0]  insertPress = 0, insertMask;
   logic [14:0] pul = 0;
   logic [12:0] tempo = 0, tagBpm, bpm;
   logic        tagValid, tagLoad, tempoLocked, delayLocked, clearLoop, clearAfterPass;
   logic [8:0]  freqIdx;
   logic [7:0]  baseDelay;
   logic [6:0]  feedback, wetMix;
   logic [11:0] echoDelay;
   logic [4:0]  drive, wordBits, srateIdx;
   logic [16:0] q[$], e;
   int          failures = 0, checks_done = 0;
   host_tag_source u_host_tag_source (.clk_sys, .send, .tempo, .tagValid, .tagLoad, .tagBpm);
   // Short windows keep fast-turn, tap and double-press runs brief
   audio_effect_parameter_control #(.FAST_CYC(20), .TAP_CYC(200), .DPR_CYC(50))
   u_audio_effect_parameter_control (
      .clk_sys, .rst_n, .clkEn, .effectSel, .effectLoad, .firstEncUp(pul[0]),
      .firstEncDown(pul[1]), .firstEncTap(pul[2]), .secondEncUp(pul[3]),
      .secondEncDown(pul[4]), .secondEncPress(pul[5]), .multJoyPress(pul[6]),
      .multJoyUp(pul[7]), .multJoyDown(pul[8]), .mixJoyPress(pul[9]), .mixJoyUp(pul[13]),
      .mixJoyDown(pul[14]), .mixJoyLeft(pul[10]), .mixJoyRight(pul[11]), .insertPress,
      .effectOnPress(pul[12]), .tagValid, .tagLoad, .tagBpm, .freqIdx, .baseDelay,
      .depth(), .lfoEnable(), .bpm, .tempoLocked, .phaseResync(), .multIdx,
      .multAllowed(), .multLed(), .secondLed(), .mixLed(), .feedback, .hpCutoff(),
      .hpResonance(), .echoDelay, .delayLocked, .wetMix, .insertMask, .effectOn(),
      .inputGate(), .clearLoop, .clearAfterPass, .drive, .srateIdx, .wordBits);
   initial forever #4 clk_sys = ~clk_sys;
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask
   // A held strobe counts once per edge
   task automatic hold(input int b, input int n);
      pul[b] = 1'b1;
      repeat (n) tick;
      pul[b] = 1'b0;
   endtask
   task automatic load(input logic [2:0] fx);
      effectSel = fx;
      effectLoad = 1'b1;
      tick;
      effectLoad = 1'b0;
      tick;
   endtask
   task automatic press(input logic [3:0] m);
      insertPress = m;
      tick;
      insertPress = 4'h0;
   endtask
   task automatic note(input logic [3:0] s, input logic [12:0] v);
      q.push_back({s, v});
   endtask
   function automatic logic [12:0] pick(input logic [3:0] s);
      case (s)
         4'h0: return 13'(freqIdx);
         4'h1: return 13'(baseDelay);
         4'h2: return bpm;
         4'h3: return 13'(multIdx);
         4'h4: return 13'(feedback);
         4'h5: return 13'(echoDelay);
         4'h6: return 13'(wetMix);
         4'h7: return 13'(insertMask);
         4'h8: return 13'(clearLoop);
         4'h9: return 13'({drive, wordBits});
         4'hA: return 13'(delayLocked);
         4'hC: return 13'(clearAfterPass);
         4'hD: return 13'(srateIdx);
         default: return 13'(tempoLocked);
      endcase
   endfunction
   task automatic check(input logic [12:0] got, input logic [12:0] want);
      checks_done++;
      if (got !== want) begin
         failures++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // Results settle by mid-cycle; oldest note is judged first
   always @(negedge clk_sys) begin
      while (q.size() > 0) begin
         e = q.pop_front();
         check(pick(e[16:13]), e[12:0]);
      end
   end
   task automatic conclude;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Whole run is about 700 cycles, far below the 12500-cycle limit
   initial begin
      #100000;
      failures++;
      conclude;
   end
   initial begin
      void'($urandom(80733));
      repeat (12) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      load(FX_PHASER);
      note(4'h0, 13'(FREQ_RST));
      note(4'h6, 13'(FB_FULL));
      note(4'h2, BPM_RST);
      load(FX_FLANGER);
      hold(0, 130);
      note(4'h1, 13'(FLG_DLY_MAX));
      load(FX_ECHO);
      note(4'h4, 13'(FB_ECHO_RST));
      note(4'h6, 13'(MIX_HALF));
      note(4'h5, 13'(DLY_RST));
      repeat (30) tick;
      hold(0, 1);
      note(4'h5, 13'h01F5);
      note(4'hA, 13'h0000);
      tick;
      hold(0, 1);
      note(4'h5, 13'h02BD);
      repeat (30) tick;
      hold(1, 1);
      note(4'h5, 13'h02BC);
      hold(3, 40);
      note(4'h4, 13'(FB_ECHO_MAX));
      press(4'h1);
      note(4'h7, 13'h0001);
      repeat (60) tick;
      press(4'h4);
      note(4'h8, 13'h0000);
      note(4'h7, 13'h0004);
      tick;
      press(4'h4);
      note(4'h8, 13'h0001);
      // Uninsert, then re-insert inside the window: only the double press clears
      tick;
      press(4'h4);
      repeat (60) tick;
      press(4'h4);
      tick;
      press(4'h4);
      note(4'h8, 13'h0001);
      note(4'h7, 13'h0004);
      hold(6, 1);
      tick;
      hold(8, 1);
      tick;
      hold(2, 1);
      repeat (100) tick;
      hold(2, 1);
      note(4'h2, BPM_MAX);
      note(4'h3, 13'(MUL_ECHO_ONE));
      // Step off unity so a tag that resets the multiplier shows
      hold(8, 1);
      tempo = BPM_MIN + 13'($urandom % 4561);
      send = 1'b1;
      tick;
      send = 1'b0;
      tick;
      note(4'h2, tempo);
      note(4'hB, 13'h0001);
      note(4'h3, 13'(MUL_ECHO_ONE + 3'h1));
      hold(4, 93);
      tick;
      hold(4, 1);
      note(4'h4, 13'h0000);
      note(4'hC, 13'h0001);
      load(FX_HOLD);
      note(4'h4, 13'(FB_FULL));
      load(FX_CRUSHER);
      note(4'h6, 13'(FB_FULL));
      note(4'h9, 13'({CRUSH_RST, BITS_MAX}));
      hold(0, 40);
      note(4'h9, 13'({DRIVE_MAX, BITS_MAX}));
      hold(3, 40);
      note(4'hD, 13'(SRATE_MAX));
      hold(9, 1);
      // Judged while the joystick is still held down
      pul[14] = 1'b1;
      note(4'h6, 13'h0000);
      tick;
      pul[14] = 1'b0;
      // Random storm across every control, judged by the checker
      repeat (40) begin
         tick;
         pul = 15'($urandom);
         insertPress = 4'($urandom);
         effectLoad = 1'($urandom);
         effectSel = 3'($urandom % 7);
         clkEn = 1'($urandom);
      end
      tick;
      conclude;
   end
endmodule

// ---- bench/fx_param_checker_properties.sv ----
module fx_param_checker
   import fx_param_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        clkEn,
   input wire logic [2:0]  effectSel,
   input wire logic        effectLoad,
   input wire logic        mixJoyUp,
   input wire logic        mixLed,
   input wire logic [7:0]  depth,
   input wire logic        lfoEnable,
   input wire logic [6:0]  feedback,
   input wire logic [8:0]  freqIdx,
   input wire logic [6:0]  wetMix,
   input wire logic [12:0] bpm,
   input wire logic [11:0] echoDelay,
   input wire logic [3:0]  insertPress,
   input wire logic        clearLoop
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so reset gates every property
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_lfo; lfoEnable == (depth != 8'h00); endproperty
   a_lfo: assert property (p_lfo) else $error("lfo enable off depth");
   property p_echo; clkEn && effectLoad && effectSel == FX_ECHO |=> feedback == FB_ECHO_RST;
   endproperty
   a_echo: assert property (p_echo) else $error("echo feedback default");
   property p_phs; clkEn && effectLoad && effectSel == FX_PHASER |=> freqIdx == FREQ_RST;
   endproperty
   a_phs: assert property (p_phs) else $error("phaser freq default");
   property p_crw; clkEn && effectLoad && effectSel == FX_CRUSHER |=> mixLed || wetMix == FB_FULL;
   endproperty
   a_crw: assert property (p_crw) else $error("crusher mix default");
   property p_wet; mixLed && mixJoyUp |-> wetMix == FB_FULL; endproperty
   a_wet: assert property (p_wet) else $error("momentary wet");
   property p_bpm; bpm >= BPM_MIN && bpm <= BPM_MAX; endproperty
   a_bpm: assert property (p_bpm) else $error("tempo out of range");
   property p_dly; echoDelay >= DLY_MIN && echoDelay <= DLY_MAX; endproperty
   a_dly: assert property (p_dly) else $error("delay out of range");
   // With no insert press nothing can renew the pulse
   property p_clr; clkEn && clearLoop && insertPress == 4'h0 |=> !clearLoop; endproperty
   a_clr: assert property (p_clr) else $error("loop clear too long");
endmodule
bind audio_effect_parameter_control fx_param_checker u_fx_param_checker (
   .clk_sys, .rst_n, .clkEn, .effectSel, .effectLoad, .mixJoyUp, .mixLed, .depth,
   .lfoEnable, .feedback, .freqIdx, .wetMix, .bpm, .echoDelay, .insertPress, .clearLoop);

// ---- bench/host_tag_source.sv ----
module host_tag_source (
   input  wire logic        clk_sys,
   input  wire logic        send,
   input  wire logic [12:0] tempo,
   output logic             tagValid,
   output logic             tagLoad,
   output logic [12:0]      tagBpm
);
   timeunit 1ns;
   timeprecision 1ns;
   logic s;
   // No track yet: tempo lines wander so stale data cannot pass
   initial begin
      tagValid = 1'b0;
      tagLoad = 1'b0;
      tagBpm = 13'h1A5A;
   end
   // Level valid, one-cycle load strobe per new track
   always @(posedge clk_sys) begin
      s = send;
      #1;
      tagLoad = s;
      if (s) begin
         tagValid = 1'b1;
         tagBpm = tempo;
      end else if (!tagValid) begin
         tagBpm = ~tagBpm;
      end
   end
endmodule

// ---- design/audio_effect_parameter_control.sv ----
module audio_effect_parameter_control
   import fx_param_pkg::*;
#(
   parameter int FAST_CYC = FAST_TURN_MS * MS_CYCLES,
   parameter int TAP_CYC  = TAP_TIMEOUT_MS * MS_CYCLES,
   parameter int DPR_CYC  = DPRESS_MS * MS_CYCLES,
   parameter int MEM_MS   = 2900
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire logic [2:0]  effectSel,
   input  wire logic        effectLoad,
   input  wire logic        firstEncUp,
   input  wire logic        firstEncDown,
   input  wire logic        firstEncTap,
   input  wire logic        secondEncUp,
   input  wire logic        secondEncDown,
   input  wire logic        secondEncPress,
   input  wire logic        multJoyPress,
   input  wire logic        multJoyUp,
   input  wire logic        multJoyDown,
   input  wire logic        mixJoyPress,
   input  wire logic        mixJoyUp,
   input  wire logic        mixJoyDown,
   input  wire logic        mixJoyLeft,
   input  wire logic        mixJoyRight,
   input  wire logic [3:0]  insertPress,
   input  wire logic        effectOnPress,
   input  wire logic        tagValid,
   input  wire logic        tagLoad,
   input  wire logic [12:0] tagBpm,
   output logic [8:0]       freqIdx,
   output logic [7:0]       baseDelay,
   output logic [7:0]       depth,
   output logic             lfoEnable,
   output logic [12:0]      bpm,
   output logic             tempoLocked,
   output logic             phaseResync,
   output logic [2:0]       multIdx,
   output logic [7:0]       multAllowed,
   output logic             multLed,
   output logic             secondLed,
   output logic             mixLed,
   output logic [6:0]       feedback,
   output logic [8:0]       hpCutoff,
   output logic [6:0]       hpResonance,
   output logic [11:0]      echoDelay,
   output logic             delayLocked,
   output logic [6:0]       wetMix,
   output logic [3:0]       insertMask,
   output logic             effectOn,
   output logic             inputGate,
   output logic             clearLoop,
   output logic             clearAfterPass,
   output logic [4:0]       drive,
   output logic [4:0]       srateIdx,
   output logic [4:0]       wordBits
);
   // ****************************************
   // Mode decode
   // ****************************************
   logic isPhaser, isFlanger, isSweep, isEcho, isHp, isHold, isCrush;
   assign isPhaser  = (effectSel == FX_PHASER);
   assign isFlanger = (effectSel == FX_FLANGER);
   assign isSweep   = isPhaser | isFlanger;
   assign isHp      = (effectSel == FX_HP_ECHO) | (effectSel == FX_HP_HOLD);
   assign isHold    = (effectSel == FX_HOLD) | (effectSel == FX_HP_HOLD);
   assign isEcho    = (effectSel == FX_ECHO) | (effectSel == FX_HP_ECHO) | isHold;
   assign isCrush   = (effectSel == FX_CRUSHER);

   logic [8:0]  freq_q;
   logic [7:0]  base_q, depth_q;
   logic [12:0] bpm_q;
   logic [2:0]  mult_q;
   logic        mled_q, sled_q, xled_q, lock_q, dlock_q, on_q, resync_q;
   logic [6:0]  fb_q, mix_q;
   logic [8:0]  hp_q;
   logic [11:0] dly_q;
   logic [3:0]  ins_q;
   logic [4:0]  drive_q, srate_q, bits_q;
   logic        clr_q, pass_q;

   // ****************************************
   // Turn speed: a second detent soon after the last is fast
   // ****************************************
   logic [27:0] turnGap_q;
   logic        firstTurn, fastTurn;
   assign firstTurn = firstEncUp | firstEncDown;
   assign fastTurn  = (turnGap_q < 28'(FAST_CYC));

   // ****************************************
   // Tap tempo: interval between taps gives BPM
   // ****************************************
   // 29 bits: the slowest legal tap gap is beyond 2^28 cycles
   logic [28:0] tapGap_q;
   logic        tapArmed_q;
   logic        tapValidGap;
   logic [39:0] tapQuot;
   logic [12:0] tapBpm;
   assign tapValidGap = tapArmed_q && (tapGap_q < 29'(TAP_CYC));
   // Divider is large and combinational, though its result is used only on taps; a serial one would save area
   assign tapQuot = (40'(CLK_HZ) * 40'd600) / 40'({11'h000, tapGap_q} + 40'd1);
   assign tapBpm  = (tapQuot < 40'(BPM_MIN)) ? BPM_MIN :
                    (tapQuot > 40'(BPM_MAX)) ? BPM_MAX : tapQuot[12:0];

   // ****************************************
   // Multiplier ladder and memory limit for echo
   // ****************************************
   logic [7:0] allowEcho;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_mult
         // Beat ms = 600000/bpm_tenths; scaled by 4,2,1,3/4,1/2,1/4,1/8,1/16
         localparam int NUM = (g == 0) ? 64 : (g == 1) ? 32 : (g == 2) ? 16 :
                              (g == 3) ? 12 : (g == 4) ? 8 : (g == 5) ? 4 :
                              (g == 6) ? 2 : 1;
         logic [39:0] need;
         assign need = (40'd600_000 * 40'(NUM)) / (40'({27'h0, bpm_q}) * 40'd16 + 40'd1);
         assign allowEcho[g] = (need <= 40'(MEM_MS));
      end
   endgenerate
   assign multAllowed = isEcho ? allowEcho : 8'hFF;

   logic [11:0] lockedDly;
   logic [39:0] lockedWide;
   logic [39:0] multNum;
   // Multiplier in sixteenths: 4..1 from 64, 3/4 is 12, halves below it from 128
   assign multNum    = (mult_q == 3'h3) ? 40'd12 :
                       (mult_q < 3'h3) ? (40'd64 >> mult_q) : (40'd128 >> mult_q);
   assign lockedWide = (40'd600_000 * multNum) / (40'({27'h0, bpm_q}) * 40'd16 + 40'd1);
   assign lockedDly  = (lockedWide > 40'(DLY_MAX)) ? DLY_MAX : lockedWide[11:0];

   // Next joystick multiplier step; up stops at a disabled echo entry, down is unchecked
   logic [2:0] multUp, multDn;
   assign multUp = (mult_q != 3'h0 && multAllowed[mult_q - 3'h1]) ? mult_q - 3'h1 : mult_q;
   assign multDn = (mult_q != 3'h7) ? mult_q + 3'h1 : mult_q;

   // ****************************************
   // Insert point double press and uninsert
   // ****************************************
   logic [3:0] dbl;
   generate
      for (g = 0; g < 4; g++) begin : g_ins
         press_detect #(.WINDOW_CYC(DPR_CYC)) u_dp (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .clkEn       (clkEn),
            .press       (insertPress[g]),
            .doublePress (dbl[g])
         );
      end
   endgenerate
   logic [3:0] insNext;
   // Single press inserts at that point only; pressing the active point removes it
   assign insNext = (insertPress == 4'h0) ? ins_q :
                    ((ins_q & insertPress) != 4'h0) ? 4'h0 : insertPress;
   logic uninsert;
   assign uninsert = (ins_q != 4'h0) && (insNext == 4'h0);

   // ****************************************
   // Encoder step helpers
   // ****************************************
   function automatic logic [11:0] stepSat(input logic [11:0] v, input logic [11:0] s,
                                           input logic up, input logic [11:0] lo,
                                           input logic [11:0] hi);
      logic [12:0] t;
      t = 13'h0000;
      if (up) begin
         t = {1'b0, v} + {1'b0, s};
         stepSat = (t > {1'b0, hi}) ? hi : t[11:0];
      end else begin
         stepSat = (v < lo + s) ? lo : v - s;
      end
   endfunction

   // ****************************************
   // Parameter state
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         freq_q <= FREQ_RST;     base_q <= FLG_DLY_RST; depth_q <= DEPTH_RST;
         bpm_q  <= BPM_RST;      mult_q <= MUL_ECHO_ONE;
         mled_q <= 1'b0;         sled_q <= 1'b0;       xled_q <= 1'b0;
         lock_q <= 1'b0;         dlock_q <= 1'b0;      on_q <= 1'b0;
         resync_q <= 1'b0;       fb_q <= FB_ECHO_RST;  mix_q <= MIX_HALF;
         hp_q   <= FREQ_HP_RST;  dly_q <= DLY_RST;     ins_q <= 4'h0;
         drive_q <= CRUSH_RST;   srate_q <= CRUSH_RST; bits_q <= BITS_MAX;
         clr_q  <= 1'b0;         pass_q <= 1'b0;
         turnGap_q <= 28'hFFF_FFFF;
         tapGap_q  <= 29'h0000_0000;
         tapArmed_q <= 1'b0;
      end else if (clkEn) begin
         resync_q <= 1'b0;
         clr_q    <= 1'b0;
         pass_q   <= 1'b0;
         turnGap_q <= firstTurn ? 28'h000_0000 :
                      (turnGap_q == 28'hFFF_FFFF) ? turnGap_q : turnGap_q + 28'h000_0001;
         tapGap_q  <= firstEncTap ? 29'h0000_0000 :
                      (tapGap_q == 29'h1FFF_FFFF) ? tapGap_q : tapGap_q + 29'h0000_0001;
         if (firstEncTap) tapArmed_q <= 1'b1;
         // Mode indicators toggle on press
         if (multJoyPress && !isCrush) mled_q <= ~mled_q;
         if (mixJoyPress) xled_q <= ~xled_q;
         if (secondEncPress && (isSweep || isHp || isCrush)) sled_q <= ~sled_q;
         if (effectOnPress) on_q <= ~on_q;
         ins_q <= insNext;
         // Effect load restores per-effect defaults
         if (effectLoad) begin
            sled_q <= 1'b0;
            if (isSweep) begin
               mix_q  <= FB_FULL;
               freq_q <= FREQ_RST;
               base_q <= FLG_DLY_RST;
               fb_q   <= FB_SWEEP_RST;
               mult_q <= MUL_SWEEP_ONE;
            end else if (isEcho) begin
               mix_q  <= MIX_HALF;
               fb_q   <= isHold ? FB_FULL : FB_ECHO_RST;
               dly_q  <= DLY_RST;
               mult_q <= MUL_ECHO_ONE;
            end else begin
               mix_q  <= FB_FULL;
            end
         end else begin
            // Tempo tag follows track; multiplier left alone
            if (tagLoad && tagValid) begin
               bpm_q   <= (tagBpm < BPM_MIN) ? BPM_MIN : (tagBpm > BPM_MAX) ? BPM_MAX : tagBpm;
               lock_q  <= 1'b1;
               dlock_q <= 1'b1;
            end
            // Tap: two taps set tempo, single tap resyncs phase
            if (firstEncTap && !isCrush) begin
               resync_q <= 1'b1;
               if (tapValidGap) begin
                  bpm_q  <= tapBpm;
                  lock_q <= 1'b0;
                  if (isEcho) begin
                     mult_q  <= MUL_ECHO_ONE;
                     dlock_q <= 1'b1;
                  end
               end else if (isEcho) begin
                  dlock_q <= 1'b1;
               end
            end
            // First encoder turns
            if (firstTurn) begin
               if (isPhaser)
                  freq_q <= 9'(stepSat({3'h0, freq_q}, 12'h001, firstEncUp, 12'h000,
                                    {3'h0, FREQ_MAX}));
               else if (isFlanger)
                  base_q <= 8'(stepSat({4'h0, base_q}, 12'h001, firstEncUp, 12'h000,
                                    {4'h0, FLG_DLY_MAX}));
               else if (isEcho) begin
                  dly_q <= stepSat(dlock_q ? lockedDly : dly_q,
                                   fastTurn ? DLY_FAST_STEP : 12'h001,
                                   firstEncUp, DLY_MIN, DLY_MAX);
                  dlock_q <= 1'b0;
               end else if (isCrush)
                  drive_q <= 5'(stepSat({7'h0, drive_q}, 12'h001, firstEncUp, 12'h000,
                                     {7'h0, DRIVE_MAX}));
            end
            // Multiplier joystick
            if (mled_q && (multJoyUp || multJoyDown) && (isSweep || isEcho)) begin
               mult_q <= multJoyUp ? multUp : multDn;
               if (isEcho) dlock_q <= 1'b1;
            end
            // Second encoder
            if (secondEncUp || secondEncDown) begin
               if (isCrush && sled_q)
                  bits_q <= 5'(stepSat({7'h0, bits_q}, 12'h001, secondEncUp, {7'h0, BITS_MIN},
                                    {7'h0, BITS_MAX}));
               else if (isCrush)
                  srate_q <= 5'(stepSat({7'h0, srate_q}, 12'h001, secondEncUp, 12'h000,
                                     {7'h0, SRATE_MAX}));
               else if (isSweep && sled_q)
                  depth_q <= 8'(stepSat({4'h0, depth_q}, 12'h001, secondEncUp, 12'h000,
                                     isPhaser ? {4'h0, PH_DEPTH_MAX} : {4'h0, FLG_DLY_MAX}));
               else if (isHp && sled_q)
                  hp_q <= 9'(stepSat({3'h0, hp_q}, 12'h001, secondEncUp, 12'h000,
                                  {3'h0, FREQ_MAX}));
               else begin
                  fb_q <= 7'(stepSat({5'h0, fb_q}, 12'h001, secondEncUp, 12'h000,
                                  {5'h0, (isEcho && !isHold) ? FB_ECHO_MAX : FB_FULL}));
                  if (isEcho && !secondEncUp && fb_q == 7'h01)
                     pass_q <= 1'b1;
               end
            end
            // Stored mix shifts with side moves
            if (xled_q && mixJoyRight && mix_q != FB_FULL) mix_q <= mix_q + 7'h01;
            if (xled_q && mixJoyLeft && mix_q != 7'h00) mix_q <= mix_q - 7'h01;
         end
         // Loop clear: uninsert or double press, never on insert move
         if (isEcho && (uninsert || (dbl != 4'h0))) clr_q <= 1'b1;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign freqIdx      = freq_q;
   assign baseDelay    = base_q;
   assign depth        = depth_q;
   assign lfoEnable    = (depth_q != 8'h00);
   assign bpm          = bpm_q;
   assign tempoLocked  = lock_q;
   assign phaseResync  = resync_q;
   assign multIdx      = mult_q;
   assign multLed      = mled_q;
   assign secondLed    = sled_q;
   assign mixLed       = xled_q;
   assign feedback     = fb_q;
   assign hpCutoff     = hp_q;
   assign hpResonance  = HP_RES_X10;
   assign echoDelay    = dlock_q ? lockedDly : dly_q;
   assign delayLocked  = dlock_q;
   // Momentary wet/dry holds override the stored ratio only while held
   assign wetMix       = !xled_q ? mix_q : mixJoyUp ? FB_FULL :
                         mixJoyDown ? 7'h00 : mix_q;
   assign insertMask   = ins_q;
   assign effectOn     = on_q;
   assign inputGate    = (ins_q != 4'h0) && (!isHold || on_q);
   assign clearLoop    = clr_q;
   assign clearAfterPass = pass_q;
   assign drive        = drive_q;
   assign srateIdx     = srate_q;
   assign wordBits     = bits_q;
endmodule

// ---- design/fx_param_pkg.sv ----
package fx_param_pkg;
   // ****************************************
   // Effect selection
   // ****************************************
   typedef enum logic [2:0] {
      FX_PHASER   = 3'h0,
      FX_FLANGER  = 3'h1,
      FX_ECHO     = 3'h2,
      FX_HP_ECHO  = 3'h3,
      FX_HOLD     = 3'h4,
      FX_HP_HOLD  = 3'h5,
      FX_CRUSHER  = 3'h6
   } effect_e;

   typedef enum logic [1:0] {
      DP_IDLE  = 2'h0,
      DP_FIRST = 2'h1,
      DP_GAP   = 2'h3
   } dpress_e;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int          CLK_HZ          = 125_000_000;
   localparam int          MS_CYCLES       = CLK_HZ / 1000;
   localparam int          DPRESS_MS       = 300;
   localparam int          FAST_TURN_MS    = 30;
   localparam int          TAP_TIMEOUT_MS  = 3000;
   localparam int          BPM_TICK_MS     = 60_000; // one minute in ms; whole-BPM scaling base

   // ****************************************
   // Frequency index: 9 octaves in 32 steps per 1 1/3 turn
   // ****************************************
   localparam logic [8:0]  FREQ_MAX        = 9'h1_20; // 288 steps span 31.5Hz..16kHz
   localparam logic [8:0]  FREQ_RST        = 9'h0_91; // 722 Hz point, log step 145
   localparam logic [8:0]  FREQ_HP_RST     = 9'h0_00;

   // Flanger delays in 0.1 ms
   localparam logic [7:0]  FLG_DLY_MAX     = 8'h74;   // 11.6 ms
   localparam logic [7:0]  FLG_DLY_RST     = 8'h00;

   // Depth in steps of 1/32 octave or 0.1 ms
   localparam logic [7:0]  PH_DEPTH_MAX    = 8'h90;   // 4.5 oct
   localparam logic [7:0]  DEPTH_RST       = 8'h00;

   // Tempo in 0.1 BPM
   localparam logic [12:0] BPM_RST         = 13'h04_B0; // 120.0
   localparam logic [12:0] BPM_MIN         = 13'h00_F0; // 24.0
   localparam logic [12:0] BPM_MAX         = 13'h12_C0; // 480.0

   // Feedback and mix in percent
   localparam logic [6:0]  FB_ECHO_RST     = 7'h46;   // 70
   localparam logic [6:0]  FB_ECHO_MAX     = 7'h5E;   // 94
   localparam logic [6:0]  FB_FULL         = 7'h64;   // 100
   localparam logic [6:0]  MIX_HALF        = 7'h32;   // 50
   localparam logic [6:0]  FB_SWEEP_RST    = 7'h00;

   // Echo delay in ms
   localparam logic [11:0] DLY_MIN         = 12'h001;
   localparam logic [11:0] DLY_MAX         = 12'hB54; // 2900
   localparam logic [11:0] DLY_RST         = 12'h1F4; // 500
   localparam logic [11:0] DLY_FAST_STEP   = 12'h0C8; // 200

   // Multiplier index: 0 = largest; unity position differs per family
   localparam logic [2:0]  MUL_SWEEP_ONE   = 3'h4;
   localparam logic [2:0]  MUL_ECHO_ONE    = 3'h2;

   // Crusher
   localparam logic [4:0]  DRIVE_MAX       = 5'h1F;   // 32 steps, 0.75 dB each
   localparam logic [4:0]  SRATE_MAX       = 5'h1F;   // 32 steps down to 34 Hz
   localparam logic [4:0]  BITS_MAX        = 5'h18;   // 24 bits
   localparam logic [4:0]  BITS_MIN        = 5'h03;
   localparam logic [4:0]  CRUSH_RST       = 5'h00;
   localparam logic [6:0]  HP_RES_X10      = 7'h07;   // fixed 0.7
endpackage

// ---- design/press_detect.sv ----
module press_detect
   import fx_param_pkg::*;
#(
   parameter int WINDOW_CYC = DPRESS_MS * MS_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic clkEn,
   input  wire logic press,
   output logic      doublePress
);
   // ****************************************
   // Double-press detector on one button pulse
   // ****************************************
   dpress_e           state_q;
   dpress_e           state_d;
   logic [27:0]       cnt_q;
   logic              expired;

   assign expired = (cnt_q >= 28'(WINDOW_CYC));

   // Second press inside window fires
   always_comb begin
      state_d     = state_q;
      doublePress = 1'b0;
      unique case (state_q)
         DP_IDLE: if (press) state_d = DP_FIRST;
         DP_FIRST: if (!press) state_d = DP_GAP;
         DP_GAP: begin
            if (press) begin
               doublePress = 1'b1;
               state_d     = DP_IDLE;
            end else if (expired) begin
               state_d = DP_IDLE;
            end
         end
         default: state_d = DP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= DP_IDLE;
         cnt_q   <= 28'h000_0000;
      end else if (clkEn) begin
         state_q <= state_d;
         cnt_q   <= (state_q == DP_IDLE) ? 28'h000_0000 : cnt_q + 28'h000_0001;
      end
   end
endmodule
